// ### inc/csp_pkg.sv
// Constants, carriers and helpers for the codec serial port block.
// Assumes one core clock domain and one serial shift clock domain.
package csp_pkg;
    localparam int         FSD_DLY       = 32;
    localparam int         FSD_MAX       = 32;
    localparam logic [7:0] FRAME_LAST    = 8'hff;
    localparam logic [7:0] FRAME_LAST_BP = 8'h3f;
    localparam logic [7:0] SEC_POS       = 8'h80;
    localparam logic [7:0] SEC_POS_BP    = 8'h20;
    localparam logic [7:0] ONE8          = 8'h01;
    localparam logic [7:0] TWO8          = 8'h02;
    localparam logic [4:0] BIT_MID       = 5'h07;
    localparam logic [4:0] BIT_LAST      = 5'h0f;
    localparam logic [2:0] REG_C1        = 3'h1;
    localparam logic [2:0] REG_C2        = 3'h2;
    localparam logic [2:0] REG_C3        = 3'h3;
    localparam logic [2:0] REG_C4        = 3'h4;
    localparam int         C1_FMT        = 0;
    localparam int         C1_BP_DAC     = 1;
    localparam int         C1_BP_ADC     = 2;
    localparam int         C1_SWRST      = 3;
    localparam int         C2_LOWPWR     = 7;
    localparam int         C3_FLAG       = 3;
    localparam int         C3_CONT       = 5;
    localparam int         LB_HI         = 7;
    localparam int         LB_LO         = 6;
    localparam int         PD_HI         = 2;
    localparam int         PD_LO         = 1;
    localparam int         SW_RD         = 12;
    localparam int         ALT_POS       = 14;
    localparam logic [1:0] LB_ANA        = 2'h1;
    localparam logic [1:0] LB_DIG        = 2'h2;
    localparam logic [1:0] LB_EVT        = 2'h3;
    localparam logic [1:0] PD_ADC        = 2'h1;
    localparam logic [1:0] PD_DAC        = 2'h2;
    localparam logic [1:0] PD_ALL        = 2'h3;
    localparam logic [7:0] C1_RST        = 8'h00;
    localparam logic [7:0] C2_RST        = 8'h00;
    localparam logic [7:0] C3_RST        = 8'h00;
    localparam logic [7:0] C4_RST        = 8'h00;

    typedef enum logic [1:0] {CSP_PULSE, CSP_SPI0, CSP_SPI1, CSP_FRAME} csp_fsmode_t;

    typedef struct packed {
        logic       swr;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic [7:0] c4;
    } csp_cfg_t;

    localparam csp_cfg_t CFG_RST = '{1'b0, C1_RST, C2_RST, C3_RST, C4_RST};

    typedef struct packed {
        logic       ms1, ms2, pd1, pd2, alt1, alt2, ovf1, ovf2;
        logic [1:0] md1, md2;
        logic       adc1, adc2, adcp;
    } csp_lsync_t;

    typedef struct packed {
        csp_lsync_t        s;
        logic [7:0]        fcnt;
        logic [4:0]        bitn;
        logic              act, sec, sec_req, fs_prev, fs_o, dout, oe;
        logic [15:0]       tx, rx, adc_l, dac_w;
        csp_cfg_t          cfg;
        logic              cfg_tg, rd_tg, dac_tg, cont_arm, cont;
        logic [FSD_MAX-1:0] fsd_sh;
    } csp_link_t;

    typedef struct packed {
        logic        pd1, pd2;
        logic        cfg1, cfg2, cfgp, dac1, dac2, dacp, rd1, rd2, rdp;
        csp_cfg_t    cfg;
        logic        ovf, adc_tg, dac_vld, flag, alb, adc_en, dac_en;
        logic [15:0] adc_h, dac_word;
    } csp_core_t;

    // Register readback, index 0 reads as zero
    function automatic logic [7:0] csp_rd(input csp_cfg_t c, input logic ovf,
                                          input logic [2:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            REG_C1:  r = {ovf, c.c1[6:0]};
            REG_C2:  r = c.c2;
            REG_C3:  r = c.c3;
            REG_C4:  r = c.c4;
            default: r = 8'h00;
        endcase
        return r;
    endfunction
endpackage

// ### core/csp_codec_port.sv
// Serial port and digital control of a voice-band codec.
// Assumes converters on clock_i and a host shifting on sclk_i.
`timescale 1ns/1ps
// Contract
// - Loopback field 01 enables analog loopback
// - Loopback field 10 feeds ADC words to DAC
// - Decimator overflow sets sticky flag
// - Flag stays until control register 1 read
// - Bypass bits skip FIR, frame rate x4
// - Loopback field 11 selects event monitor
// - Event monitor drives flag, shows monitor input
// - Reset pin or soft bit clears everything
// - Soft power-down stops data, keeps registers
// - Power-down pin freezes logic, refuses input
// - Master makes frame sync; 256 shift clocks per frame
// - Data out MSB first, released after LSB
// - Unrequested secondary low byte reads zero
// - Master select pin copied into words
// - Fifteen-plus-one: primary LSB requests secondary
// - Delayed frame sync 32 shift clocks later
// - Mode pins select frame sync format
// - Pulse one clock wide; frame low throughout
// - Continuous transfer blocks syncs and secondaries
// - Secondary read uses D12 and D11..D9
// - Power-down field 01 ADC, 10 DAC off
module csp_codec_port #(
    parameter int FSD_DELAY = csp_pkg::FSD_DLY
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        sclk_i,
    input  wire logic        power_down_n_i,
    input  wire logic        master_sel_i,
    input  wire logic        if_mode_bit0_i,
    input  wire logic        if_mode_bit1_i,
    input  wire logic        hw_secondary_req_i,
    input  wire logic        alt_monitor_in_i,
    input  wire logic        frame_sync_i,
    input  wire logic        din_i,
    input  wire logic [15:0] adc_word_i,
    input  wire logic        adc_valid_i,
    input  wire logic        dec_overflow_i,
    output logic             frame_sync_o,
    output logic             frame_sync_oe_o,
    output logic             dout_o,
    output logic             dout_oe_o,
    output logic             delayed_frame_sync_o,
    output logic [15:0]      dac_word_o,
    output logic             dac_valid_o,
    output logic             fir_overflow_o,
    output logic             flag_o,
    output logic             analog_loopback_o,
    output logic             adc_enable_o,
    output logic             dac_enable_o,
    output logic             fir_bypass_dac_o,
    output logic             fir_bypass_adc_o,
    output logic             low_power_o,
    output logic             internal_clk_en_o
);
    import csp_pkg::*;

    localparam int FSD_LAG = FSD_DELAY - 1;

    if (FSD_DELAY < 2 || FSD_DELAY > FSD_MAX) begin : g_chk
        $error("FSD_DELAY out of range");
    end

    csp_link_t l_r, l_nxt;
    csp_core_t c_r, c_nxt;
    logic      cfg_ev, rd_ev;

    // Link side, shift clock domain
    always_comb begin
        logic [15:0] w, wd;
        logic [7:0]  last, secp, rb;
        logic        byp, swpd, master, st_p, st_s, pre, fs_in;
        csp_fsmode_t md;
        csp_link_t   t;
        w      = {l_r.rx[14:0], din_i};
        wd     = 16'h0000;
        rb     = 8'h00;
        t      = l_r;
        l_nxt  = l_r;
        byp    = l_r.cfg.c1[C1_BP_DAC] | l_r.cfg.c1[C1_BP_ADC];
        last   = byp ? FRAME_LAST_BP : FRAME_LAST;
        secp   = byp ? SEC_POS_BP : SEC_POS;
        swpd   = l_r.cfg.c3[PD_HI:PD_LO] == PD_ALL;
        master = l_r.s.ms2;
        md     = csp_fsmode_t'(l_r.s.md2);
        fs_in  = frame_sync_i;
        st_p   = 1'b0;
        st_s   = 1'b0;
        pre    = 1'b0;

        l_nxt.s.ms1  = master_sel_i;
        l_nxt.s.ms2  = l_r.s.ms1;
        l_nxt.s.pd1  = power_down_n_i;
        l_nxt.s.pd2  = l_r.s.pd1;
        l_nxt.s.alt1 = alt_monitor_in_i;
        l_nxt.s.alt2 = l_r.s.alt1;
        l_nxt.s.ovf1 = c_r.ovf;
        l_nxt.s.ovf2 = l_r.s.ovf1;
        l_nxt.s.md1  = {if_mode_bit1_i, if_mode_bit0_i};
        l_nxt.s.md2  = l_r.s.md1;
        l_nxt.s.adc1 = c_r.adc_tg;
        l_nxt.s.adc2 = l_r.s.adc1;
        l_nxt.s.adcp = l_r.s.adc2;

        if (l_r.s.pd2) begin
            if (l_r.s.adc2 != l_r.s.adcp) begin
                l_nxt.adc_l = c_r.adc_h;
            end
            l_nxt.fcnt    = (l_r.fcnt >= last) ? 8'h00 : 8'(l_r.fcnt + ONE8);
            l_nxt.fs_prev = fs_in;
            if (l_r.cont) begin
                st_p = l_r.act && l_r.bitn == BIT_LAST;
            end else if (master) begin
                st_p = l_r.fcnt == last;
                st_s = l_r.sec_req && l_r.fcnt == 8'(secp - ONE8);
                pre  = l_r.fcnt == 8'(last - ONE8) ||
                       (l_r.sec_req && l_r.fcnt == 8'(secp - TWO8));
            end else if (md == CSP_PULSE ? fs_in : (l_r.fs_prev && !fs_in)) begin
                st_s = l_r.sec_req;
                st_p = !l_r.sec_req;
            end
            if (st_p && !master) begin
                l_nxt.fcnt = 8'h00;
            end

            if (l_r.act) begin
                l_nxt.rx   = w;
                l_nxt.bitn = 5'(l_r.bitn + 5'h01);
                l_nxt.dout = l_r.tx[15];
                l_nxt.tx   = {l_r.tx[14:0], 1'b0};
                if (l_r.sec && l_r.bitn == BIT_MID) begin
                    if (w[SW_RD - 8]) begin
                        rb = csp_rd(l_r.cfg, l_r.s.ovf2, w[3:1]);
                        if (w[3:1] == REG_C1) begin
                            l_nxt.rd_tg = !l_r.rd_tg;
                        end
                    end
                    l_nxt.dout = rb[7];
                    l_nxt.tx   = {rb[6:0], 9'h000};
                end
                if (l_r.bitn == BIT_LAST) begin
                    l_nxt.act = 1'b0;
                    l_nxt.oe  = 1'b0;
                    if (!l_r.sec) begin
                        if (!swpd) begin
                            l_nxt.dac_w  = l_r.cfg.c1[C1_FMT] ? w : {w[15:1], 1'b0};
                            l_nxt.dac_tg = !l_r.dac_tg;
                        end
                        if (!l_r.cont && !l_r.cont_arm &&
                            ((!l_r.cfg.c1[C1_FMT] && w[0]) || hw_secondary_req_i)) begin
                            l_nxt.sec_req = 1'b1;
                        end
                    end else if (!w[SW_RD]) begin
                        l_nxt.cfg.swr = 1'b0;
                        l_nxt.cfg_tg  = !l_r.cfg_tg;
                        case (w[11:9])
                            REG_C1: begin
                                l_nxt.cfg.c1 = {1'b0, w[6:4], 1'b0, w[2:0]};
                                l_nxt.cfg.swr = w[C1_SWRST];
                            end
                            REG_C2: l_nxt.cfg.c2 = w[7:0];
                            REG_C3: begin
                                l_nxt.cfg.c3 = w[7:0];
                                if (w[C3_CONT] && master) begin
                                    l_nxt.cont_arm = 1'b1;
                                end
                            end
                            REG_C4: l_nxt.cfg.c4 = w[7:0];
                            default: l_nxt.cfg_tg = l_r.cfg_tg;
                        endcase
                    end
                end
            end

            if (st_p || st_s) begin
                wd = st_s ? {master, 15'h0000} : {l_r.adc_l[15:1], master};
                if (st_s && l_r.cfg.c3[LB_HI:LB_LO] == LB_EVT) begin
                    wd[ALT_POS] = l_r.s.alt2;
                end
                l_nxt.act     = 1'b1;
                l_nxt.bitn    = 5'h00;
                l_nxt.sec     = st_s;
                l_nxt.oe      = !swpd;
                l_nxt.dout    = wd[15];
                l_nxt.tx      = {wd[14:0], 1'b0};
                l_nxt.sec_req = l_r.sec_req && !st_s;
                if (st_p && l_r.cont_arm) begin
                    l_nxt.cont     = 1'b1;
                    l_nxt.cont_arm = 1'b0;
                end
            end

            if (md == CSP_PULSE) begin
                l_nxt.fs_o = pre;
            end else begin
                l_nxt.fs_o = l_r.cont || !(l_nxt.act && !l_r.cont);
            end
            l_nxt.fsd_sh = {l_r.fsd_sh[FSD_MAX-2:0],
                            !swpd && (master ? l_r.fs_o : fs_in)};
        end

        if (l_nxt.cfg.swr && l_r.s.pd2 && !l_r.cfg.swr) begin
            t      = l_nxt;
            l_nxt  = '0;
            l_nxt.s       = t.s;
            l_nxt.cfg     = CFG_RST;
            l_nxt.cfg.swr = 1'b1;
            l_nxt.cfg_tg  = t.cfg_tg;
            l_nxt.rd_tg   = t.rd_tg;
            l_nxt.dac_tg  = t.dac_tg;
        end
    end

    always_ff @(posedge sclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    assign cfg_ev = c_r.cfg2 != c_r.cfgp;
    assign rd_ev  = c_r.rd2 != c_r.rdp;

    // Core side, master clock domain
    always_comb begin
        logic [1:0] lb, pd;
        lb         = c_r.cfg.c3[LB_HI:LB_LO];
        pd         = c_r.cfg.c3[PD_HI:PD_LO];
        c_nxt      = c_r;
        c_nxt.pd1  = power_down_n_i;
        c_nxt.pd2  = c_r.pd1;
        c_nxt.cfg1 = l_r.cfg_tg;
        c_nxt.cfg2 = c_r.cfg1;
        c_nxt.cfgp = c_r.cfg2;
        c_nxt.dac1 = l_r.dac_tg;
        c_nxt.dac2 = c_r.dac1;
        c_nxt.dacp = c_r.dac2;
        c_nxt.rd1  = l_r.rd_tg;
        c_nxt.rd2  = c_r.rd1;
        c_nxt.rdp  = c_r.rd2;
        c_nxt.dac_vld = 1'b0;

        if (cfg_ev) begin
            c_nxt.cfg = l_r.cfg;
            if (l_r.cfg.c3[LB_HI:LB_LO] == LB_EVT) begin
                c_nxt.flag = l_r.cfg.c3[C3_FLAG];
            end
        end
        if (rd_ev) begin
            c_nxt.ovf = 1'b0;
        end
        if (dec_overflow_i) begin
            c_nxt.ovf = 1'b1;
        end
        if (c_r.pd2) begin
            if (adc_valid_i && c_r.adc_en) begin
                c_nxt.adc_h  = adc_word_i;
                c_nxt.adc_tg = !c_r.adc_tg;
            end
            if (lb == LB_DIG) begin
                if (adc_valid_i) begin
                    c_nxt.dac_word = adc_word_i;
                    c_nxt.dac_vld  = 1'b1;
                end
            end else if (c_r.dac2 != c_r.dacp && c_r.dac_en) begin
                c_nxt.dac_word = l_r.dac_w;
                c_nxt.dac_vld  = 1'b1;
            end
        end
        c_nxt.alb    = c_r.pd2 && lb == LB_ANA;
        c_nxt.adc_en = c_r.pd2 && pd != PD_ADC && pd != PD_ALL;
        c_nxt.dac_en = c_r.pd2 && pd != PD_DAC && pd != PD_ALL;

        if (cfg_ev && l_r.cfg.swr) begin
            c_nxt.ovf      = dec_overflow_i;
            c_nxt.flag     = 1'b0;
            c_nxt.adc_h    = 16'h0000;
            c_nxt.dac_word = 16'h0000;
            c_nxt.dac_vld  = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c_r <= '0;
        end else begin
            c_r <= c_nxt;
        end
    end

    assign frame_sync_o         = l_r.fs_o;
    assign frame_sync_oe_o      = l_r.s.ms2;
    assign dout_o               = l_r.dout;
    assign dout_oe_o            = l_r.oe;
    assign delayed_frame_sync_o = l_r.fsd_sh[FSD_DELAY-1];
    assign dac_word_o           = c_r.dac_word;
    assign dac_valid_o          = c_r.dac_vld;
    assign fir_overflow_o       = c_r.ovf;
    assign flag_o               = c_r.flag;
    assign analog_loopback_o    = c_r.alb;
    assign adc_enable_o         = c_r.adc_en;
    assign dac_enable_o         = c_r.dac_en;
    assign fir_bypass_dac_o     = c_r.cfg.c1[C1_BP_DAC];
    assign fir_bypass_adc_o     = c_r.cfg.c1[C1_BP_ADC];
    assign low_power_o          = c_r.cfg.c2[C2_LOWPWR];
    assign internal_clk_en_o    = c_r.pd2;

    // Word length taken from the bit counter, then release
    sequence word_out_s;
        ##15 (dout_oe_o && l_r.bitn == BIT_LAST) ##1 !dout_oe_o;
    endsequence

    oe_word_len_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i || !l_r.s.pd2)
        $rose(dout_oe_o) && !l_r.cont_arm && !l_r.cont |-> word_out_s)
        else $error("data out window not sixteen bits");

    ms_bit_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        l_r.act && !l_r.sec && l_r.bitn == BIT_LAST && dout_oe_o |-> dout_o == l_r.s.ms2)
        else $error("primary LSB is not master select");

    // Soft reset empties the delay line; checks in flight are dropped
    fsd_lag_a: assert property (@(posedge sclk_i)
        disable iff (!rst_n_i || !l_r.s.pd2 || l_r.cfg.swr)
        $rose(l_r.fsd_sh[0]) |-> ##FSD_LAG $rose(delayed_frame_sync_o))
        else $error("delayed frame sync misplaced");

    pulse_fs_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        l_r.s.ms2 && l_r.s.md2 == CSP_PULSE && $rose(frame_sync_o) |=> !frame_sync_o)
        else $error("frame sync pulse wider than one clock");

    swpd_dout_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        l_r.cfg.c3[PD_HI:PD_LO] == PD_ALL |-> !dout_oe_o)
        else $error("data out driven in soft power-down");

    hwpd_hold_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        !l_r.s.pd2 |=> $stable(l_r.fcnt) && $stable(l_r.cfg))
        else $error("link moved during power-down");

    ovf_set_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        dec_overflow_i |=> fir_overflow_o)
        else $error("overflow flag not set");

    ovf_sticky_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        fir_overflow_o && !rd_ev && !cfg_ev |=> fir_overflow_o)
        else $error("overflow flag lost without read");

    flag_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        c_r.cfg.c3[LB_HI:LB_LO] == LB_EVT |-> flag_o == c_r.cfg.c3[C3_FLAG])
        else $error("flag pin does not follow event bit");

    dig_loop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        c_r.pd2 && !cfg_ev && c_r.cfg.c3[LB_HI:LB_LO] == LB_DIG && adc_valid_i
        |=> dac_valid_o && dac_word_o == $past(adc_word_i))
        else $error("digital loopback word not passed");

    // No sync pulse and no secondary once words run back to back
    cont_quiet_a: assert property (@(posedge sclk_i) disable iff (!rst_n_i)
        l_r.cont |-> !l_r.sec && !l_r.sec_req &&
                     (l_r.s.md2 != CSP_PULSE || !$stable(l_r.s.md2) || !frame_sync_o))
        else $error("frame sync or secondary during continuous transfer");

    alb_follow_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        c_r.pd2 && c_r.cfg.c3[LB_HI:LB_LO] == LB_ANA |=> analog_loopback_o)
        else $error("analog loopback not enabled");

    adc_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        c_r.cfg.c3[PD_HI:PD_LO] == PD_ADC |=> !adc_enable_o)
        else $error("converter input path not switched off");
endmodule

// ### tb/csp_host_model.sv
// Host serial-port model: shifts queued words into din, captures dout words.
// Assumes the device raises dout_oe for each 16-bit word it sends.
`timescale 1ns/1ps
module csp_host_model (
    input  wire logic sclk_i,
    input  wire logic dout_i,
    input  wire logic dout_oe_i,
    output logic      din_o
);
    logic [15:0] txq[$];
    logic [15:0] rxq[$];
    logic [15:0] tx_w = 16'h0000;
    logic [15:0] rx_w = 16'h0000;
    int          nb = 0;
    int          nr = 0;
    logic        tag = 1'b0;
    initial din_o = 1'b0;
    // Bit set up before each sampling edge, MSB first
    always @(negedge sclk_i) begin
        if (dout_oe_i && nb < 16) begin
            if (nb == 0) begin
                tag = txq.size() > 0;
                tx_w = tag ? txq.pop_front() : 16'h0000;
            end
            din_o = tx_w[15 - nb];
            nb = nb + 1;
        end else begin
            if (!dout_oe_i)
                nb = 0;
            din_o = ~din_o; // Released line, no keeper
        end
    end
    // Only words sent from the queue are reported
    always @(posedge sclk_i) begin
        if (dout_oe_i) begin
            rx_w = {rx_w[14:0], dout_i};
            nr = nr + 1;
            if (nr == 16 && tag)
                rxq.push_back(rx_w);
            if (nr == 16)
                nr = 0;
        end
    end
endmodule

// ### tb/tb_csp_codec_port.sv
// Testbench of the codec serial port: register traffic over the serial link.
// Assumes master mode with a free-running 12 ns shift clock.
`timescale 1ns/1ps
module tb_csp_codec_port;
    import csp_pkg::*;
    logic        clock_i = 1'b0;
    logic        sclk = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        pdn = 1'b1;
    logic        m0 = 1'b0;
    logic        m1 = 1'b0;
    logic        adc_v = 1'b0;
    logic        ovf = 1'b0;
    logic        alt = 1'b0;
    logic [15:0] adc_w = 16'h0000;
    logic [15:0] dac_w, p, r;
    logic        din, fs_o, fs_oe, dout, dout_oe, dfs, dac_v, fovf, flag, alb;
    logic        adc_en, dac_en, bpd, bpa, lp, clk_en;
    int          fails = 0;
    int          compares = 0;
    int          cyc = 0;

    csp_codec_port #(.FSD_DELAY(FSD_DLY)) csp_codec_port_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .power_down_n_i(pdn),
        .master_sel_i(1'b1), .if_mode_bit0_i(m0), .if_mode_bit1_i(m1),
        .hw_secondary_req_i(1'b0),
        .alt_monitor_in_i(alt), .frame_sync_i(1'b0), .din_i(din), .adc_word_i(adc_w),
        .adc_valid_i(adc_v), .dec_overflow_i(ovf), .frame_sync_o(fs_o),
        .frame_sync_oe_o(fs_oe), .dout_o(dout), .dout_oe_o(dout_oe),
        .delayed_frame_sync_o(dfs), .dac_word_o(dac_w), .dac_valid_o(dac_v),
        .fir_overflow_o(fovf), .flag_o(flag), .analog_loopback_o(alb),
        .adc_enable_o(adc_en), .dac_enable_o(dac_en), .fir_bypass_dac_o(bpd),
        .fir_bypass_adc_o(bpa), .low_power_o(lp), .internal_clk_en_o(clk_en));
    csp_host_model csp_host_model_inst (
        .sclk_i(sclk), .dout_i(dout), .dout_oe_i(dout_oe), .din_o(din));

    initial forever #2.5 clock_i = ~clock_i;
    initial begin
        #3.7;
        forever #6 sclk = ~sclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            test_done();
        end
    end
    task automatic clk(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic adc_in(input logic [15:0] w);
        adc_w = w;
        adc_v = 1'b1;
        clk(1);
        adc_v = 1'b0;
    endtask
    function automatic logic [15:0] wrw(input logic [2:0] a, input logic [7:0] d);
        return {4'h0, a, 1'b0, d};
    endfunction
    function automatic logic [15:0] rdw(input logic [2:0] a);
        return {4'h1, a, 9'h000};
    endfunction
    // Primary carrying a request bit, then one secondary word
    task automatic sec(input logic [15:0] w, output logic [15:0] pri, output logic [15:0] rep);
        csp_host_model_inst.rxq.delete();
        csp_host_model_inst.txq.push_back(16'h0001);
        csp_host_model_inst.txq.push_back(w);
        for (int i = 0; i < 4000 && csp_host_model_inst.rxq.size() < 2; i++)
            clk(1);
        pri = csp_host_model_inst.rxq.size() > 1 ? csp_host_model_inst.rxq[0] : 16'hxxxx;
        rep = csp_host_model_inst.rxq.size() > 1 ? csp_host_model_inst.rxq[1] : 16'hxxxx;
        clk(20);
    endtask
    task automatic fsmeas(input logic [1:0] md, input int lows_exp);
        int   lows, fr, dr;
        logic pf, pd;
        lows = 0;
        fr = -1;
        dr = -1;
        pf = 1'b1;
        pd = 1'b1;
        {m1, m0} = md;
        repeat (300) @(posedge sclk);
        for (int i = 0; i < 560; i++) begin
            @(posedge sclk);
            if (i < 256 && !fs_o)
                lows++;
            if (fs_o && !pf && fr < 0)
                fr = i;
            if (dfs && !pd && fr >= 0 && dr < 0)
                dr = i;
            pf = fs_o;
            pd = dfs;
        end
        chk(16'(lows), 16'(lows_exp));
        chk(16'(dr - fr), 16'(FSD_DLY));
        @(negedge clock_i);
    endtask

    initial begin
        int n, m;
        n = 0;
        m = 0;
        clk(12);
        rst_n_i = 1'b1;
        clk(20);
        chk(16'(fs_oe), 16'h0001);
        chk(16'(clk_en), 16'h0001);
        chk(16'({adc_en, dac_en}), 16'h0003);
        adc_in(16'h1234);
        sec(wrw(REG_C2, 8'h80), p, r);
        chk(p, 16'h1235);
        chk(r, 16'h8000);
        chk(16'(lp), 16'h0001);
        sec(rdw(REG_C2), p, r);
        chk(r, 16'h8080);
        ovf = 1'b1;
        clk(1);
        ovf = 1'b0;
        clk(3);
        chk(16'(fovf), 16'h0001);
        clk(100);
        chk(16'(fovf), 16'h0001);
        sec(rdw(REG_C1), p, r);
        chk(r, 16'h8080);
        chk(16'(fovf), 16'h0000);
        sec(wrw(REG_C1, 8'h06), p, r);
        chk(16'({bpd, bpa}), 16'h0003);
        sec(wrw(REG_C1, 8'h08), p, r);
        chk(16'({bpd, bpa, lp}), 16'h0000);
        sec(rdw(REG_C2), p, r);
        chk(r, 16'h8000);
        fsmeas(2'b00, 255);
        fsmeas(2'b11, 16);
        {m1, m0} = 2'b00;
        clk(800);
        for (int k = 1; k < 3; k++) begin
            sec(wrw(REG_C3, 8'(2 * k)), p, r);
            chk(16'({adc_en, dac_en}), 16'(k));
        end
        sec(wrw(REG_C3, 8'h40), p, r);
        chk(16'(alb), 16'h0001);
        alt = 1'b1;
        sec(wrw(REG_C3, 8'hc8), p, r);
        chk(16'(flag), 16'h0001);
        sec(rdw(REG_C3), p, r);
        chk(r, 16'hc0c8);
        sec(wrw(REG_C3, 8'h80), p, r);
        chk(16'(alb), 16'h0000);
        adc_in(16'h5a5a);
        for (int i = 0; i < 4 && dac_v !== 1'b1; i++)
            clk(1);
        chk(16'(dac_v), 16'h0001);
        chk(dac_w, 16'h5a5a);
        sec(wrw(REG_C3, 8'h06), p, r);
        repeat (600) begin
            @(posedge sclk);
            if (dout_oe)
                n++;
        end
        chk(16'(n), 16'h0000);
        @(negedge clock_i);
        rst_n_i = 1'b0;
        clk(12);
        rst_n_i = 1'b1;
        pdn = 1'b0;
        clk(10);
        chk(16'(clk_en), 16'h0000);
        repeat (600) begin
            @(posedge sclk);
            if (dout_oe)
                n++;
        end
        chk(16'(n), 16'h0000);
        @(negedge clock_i);
        pdn = 1'b1;
        clk(10);
        chk(16'(clk_en), 16'h0001);
        sec(rdw(REG_C1), p, r);
        chk(r, 16'h8000);
        sec(wrw(REG_C3, 8'h20), p, r);
        chk(r, 16'h8000);
        repeat (150) @(posedge sclk);
        repeat (600) begin
            @(posedge sclk);
            if (!dout_oe || fs_o)
                m++;
        end
        chk(16'(m), 16'h0000);
        test_done();
    end
endmodule
